/* rtl/cic_consts.vh */
`ifndef CIC_CONSTS_VH
`define CIC_CONSTS_VH

// register byte offsets
`define CIC_OFF_CTRL        8'h00
`define CIC_OFF_STATUS      8'h04
`define CIC_OFF_ICTYPE      8'h08
`define CIC_OFF_CALIB       8'h0C
`define CIC_OFF_AFSR        8'h10
`define CIC_OFF_CONFIG      8'h14
`define CIC_OFF_IRQ_LO      8'h18
`define CIC_OFF_IRQ_HI      8'h1C

// control fields
`define CIC_CTRL_TICK_EN    0
`define CIC_CTRL_RST_EN     1
`define CIC_CTRL_RESET      2'h3

// status fields
`define CIC_ST_RST_SEEN     0
`define CIC_ST_SLOW         1
`define CIC_ST_RST_IN_SLOW  2
`define CIC_ST_TICK_LVL     3

// build options
`define CIC_IRQ_COUNT       37
`define CIC_LINES_FIELD     5'h01
`define CIC_PRIO_BITS       4'h3
`define CIC_MPU_PRESENT     1'h0
`define CIC_TRACE_PRESENT   1'h1

// tick reference and calibration
`define CIC_TICK_DIV        32
`define CIC_CALIB_VALUE     24'h0009C4
`define CIC_NO_REFERENCE_FLAG_BIT       31
`define CIC_CALIBRATION_INEXACT_FLAG_BIT        30
`define CIC_AFSR_VALUE      32'h00000000

// config register fields
`define CIC_CFG_MPU_BIT     8
`define CIC_CFG_TRACE_BIT   9
`define CIC_CFG_COUNT_LSB   16

// timing
`define CIC_CLK_PERIOD_NS   100
`define CIC_RST_PULSE_NS    1000
`define CIC_RST_PULSE_CYC   ((`CIC_RST_PULSE_NS + `CIC_CLK_PERIOD_NS - 1) / `CIC_CLK_PERIOD_NS)

`endif

/* rtl/cic_sync2.v */
`timescale 1ns/1ps

module cic_sync2 #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta_q;

  // first stage feeds the second stage only
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= {W{1'b0}};
      q      <= {W{1'b0}};
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end

endmodule // cic_sync2

/* rtl/cic_core_integration.v */
// Function
// - exactly 37 interrupt request lines are passed on to the core interrupt controller.
// - the interrupt line count field of the controller type register reads binary 00001.
// - the core is built with three implemented priority bits.
// - the tick timer reference clock is the high speed oscillator input divided by 32.
// - the tick calibration value is fixed at 0x9C4, ten milliseconds at an 8 MHz oscillator.
// - the no reference flag and the calibration inexact flag both read as zero.
// - a system reset request from the core causes a system reset.
// - the core core_output_a output is left unused; only the non maskable interrupt or reset leave core_output_a.
// - the auxiliary fault status register always reads all zeros.
// - the core event input and event output are not connected.
// - the core deep sleep output is ignored.
// - no exclusive access monitor is provided on the data code bus.
// - the core is built without memory protection and with the instruction trace unit.
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/1ps
`include "cic_consts.vh"

module cic_core_integration #(
  parameter IRQ_N  = `CIC_IRQ_COUNT,
  parameter ADDR_W = 8
) (
  input  wire              pclk,
  input  wire              presetn,
  input  wire [ADDR_W-1:0] paddr,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [31:0]       pwdata,
  output reg               pready,
  output reg  [31:0]       prdata,
  output reg               pslverr,
  input  wire              high_speed_osc_input,
  input  wire              slow_clock_mode,
  input  wire [IRQ_N-1:0]  irq_src,
  input  wire              system_reset_request,
  input  wire              core_output_a,
  input  wire              deep_sleep_output,
  input  wire              core_event_out,
  input  wire              core_excl_req,
  output reg  [IRQ_N-1:0]  core_irq,
  output reg               tick_ref_clk,
  output reg  [23:0]       calib_value,
  output reg               no_reference_flag,
  output reg               calibration_inexact_flag,
  output reg  [4:0]        interrupt_line_count_field,
  output reg  [3:0]        cfg_priority_bits,
  output reg               cfg_mpu_present,
  output reg               cfg_trace_present,
  output reg               core_event_in,
  output reg  [31:0]       core_aux_fault,
  output reg               core_excl_okay,
  output reg               sys_reset_n
);

  localparam integer HALF_DIV_I = (`CIC_TICK_DIV / 2) - 1;
  localparam integer RST_LAST_I = `CIC_RST_PULSE_CYC - 1;
  localparam integer IRQ_N_I    = IRQ_N;
  localparam [4:0]   HALF_DIV   = HALF_DIV_I[4:0];
  localparam [7:0]   RST_LAST   = RST_LAST_I[7:0];
  localparam [7:0]   IRQ_CNT8   = IRQ_N_I[7:0];

  // core_output_a, deep_sleep_output, core_event_out and core_excl_req are
  // deliberately never read: the device has no use for them

  // ---------------------------------------------------------------
  // pin synchronisers
  wire [IRQ_N-1:0] irq_sync;
  wire             osc_sync;
  wire             slow_sync;

  cic_sync2 #(
    .W (IRQ_N + 2)
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({irq_src, high_speed_osc_input, slow_clock_mode}),
    .q     ({irq_sync, osc_sync, slow_sync})
  );

  // ---------------------------------------------------------------
  // interrupt lines to the core, one flop per line
  genvar gi;
  generate
    for (gi = 0; gi < IRQ_N; gi = gi + 1) begin : g_irq
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          core_irq[gi] <= 1'b0;
        end else begin
          core_irq[gi] <= irq_sync[gi];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // fixed build options and tie offs, held in flops so outputs are registered
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      calib_value                <= `CIC_CALIB_VALUE;
      no_reference_flag          <= 1'b0;
      calibration_inexact_flag   <= 1'b0;
      interrupt_line_count_field <= `CIC_LINES_FIELD;
      cfg_priority_bits          <= `CIC_PRIO_BITS;
      cfg_mpu_present            <= `CIC_MPU_PRESENT;
      cfg_trace_present          <= `CIC_TRACE_PRESENT;
      core_event_in              <= 1'b0;
      core_aux_fault             <= `CIC_AFSR_VALUE;
      core_excl_okay             <= 1'b0;
    end else begin
      calib_value                <= `CIC_CALIB_VALUE;
      no_reference_flag          <= 1'b0;
      calibration_inexact_flag   <= 1'b0;
      interrupt_line_count_field <= `CIC_LINES_FIELD;
      cfg_priority_bits          <= `CIC_PRIO_BITS;
      cfg_mpu_present            <= `CIC_MPU_PRESENT;
      cfg_trace_present          <= `CIC_TRACE_PRESENT;
      core_event_in              <= 1'b0;
      core_aux_fault             <= `CIC_AFSR_VALUE;
      core_excl_okay             <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // control register
  reg  [1:0] ctrl_q;
  wire       tick_en = ctrl_q[`CIC_CTRL_TICK_EN];
  wire       rst_en  = ctrl_q[`CIC_CTRL_RST_EN];

  // ---------------------------------------------------------------
  // tick reference: sampled oscillator edges counted on pclk.
  // limitation: pclk must run well above twice the oscillator rate or
  // edges are lost and the reference runs slow
  reg        osc_prev_q;
  reg  [4:0] div_q;
  reg  [4:0] div_d;
  reg        tick_d;
  wire       osc_rise = osc_sync & ~osc_prev_q;

  always @* begin
    div_d  = div_q;
    tick_d = tick_ref_clk;
    if (!tick_en) begin
      // held low while disabled so the first period after enable is whole
      div_d  = 5'h00;
      tick_d = 1'b0;
    end else if (osc_rise) begin
      if (div_q == HALF_DIV) begin
        div_d  = 5'h00;
        tick_d = ~tick_ref_clk;
      end else begin
        div_d = div_q + 5'h01;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_prev_q   <= 1'b0;
      div_q        <= 5'h00;
      tick_ref_clk <= 1'b0;
    end else begin
      osc_prev_q   <= osc_sync;
      div_q        <= div_d;
      tick_ref_clk <= tick_d;
    end
  end

  // ---------------------------------------------------------------
  // system reset from the core request.
  // the request comes from core logic on pclk, so it is not synchronised.
  // the pulse is stretched so a short request still gives a clean reset
  localparam [1:0] RS_IDLE = 2'b01;
  localparam [1:0] RS_HOLD = 2'b10;

  reg  [1:0] rs_state_q;
  reg  [1:0] rs_state_d;
  reg  [7:0] rst_cnt_q;
  reg  [7:0] rst_cnt_d;
  reg        sys_reset_d;
  reg        req_prev_q;
  wire       req_rise = system_reset_request & ~req_prev_q;
  wire       req_take = req_rise & rst_en;

  // a new request edge restarts the full pulse from either state
  always @* begin
    rs_state_d  = rs_state_q;
    rst_cnt_d   = rst_cnt_q;
    sys_reset_d = 1'b1;
    case (rs_state_q)
      RS_IDLE: begin
        if (req_take) begin
          rs_state_d  = RS_HOLD;
          rst_cnt_d   = RST_LAST;
          sys_reset_d = 1'b0;
        end
      end
      RS_HOLD: begin
        sys_reset_d = 1'b0;
        if (req_take) begin
          rst_cnt_d = RST_LAST;
        end else if (rst_cnt_q == 8'h00) begin
          rs_state_d  = RS_IDLE;
          sys_reset_d = 1'b1;
        end else begin
          rst_cnt_d = rst_cnt_q - 8'h01;
        end
      end
      default: begin
        rs_state_d = RS_IDLE;
        rst_cnt_d  = 8'h00;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_prev_q  <= 1'b0;
      rs_state_q  <= RS_IDLE;
      rst_cnt_q   <= 8'h00;
      sys_reset_n <= 1'b1;
    end else begin
      req_prev_q  <= system_reset_request;
      rs_state_q  <= rs_state_d;
      rst_cnt_q   <= rst_cnt_d;
      sys_reset_n <= sys_reset_d;
    end
  end

  // ---------------------------------------------------------------
  // apb decode
  wire setup  = psel & ~penable;
  wire access = psel & penable & pready;
  wire wr_acc = access & pwrite;

  reg  [31:0] rd_mux;
  reg         hit;

  // status flags
  reg st_rst_seen_q;
  reg st_rst_slow_q;

  wire [31:0] status_word = {28'h0000000,
                             tick_ref_clk,
                             st_rst_slow_q,
                             slow_sync,
                             st_rst_seen_q};

  wire [31:0] calib_word  = {1'b0, 1'b0, 6'h00, calib_value};

  wire [31:0] config_word = {8'h00,
                             IRQ_CNT8,
                             6'h00,
                             cfg_trace_present,
                             cfg_mpu_present,
                             4'h0,
                             cfg_priority_bits};

  wire [63:0] irq_wide    = {{(64 - IRQ_N){1'b0}}, core_irq};

  always @* begin
    rd_mux = 32'h00000000;
    hit    = 1'b1;
    case (paddr)
      `CIC_OFF_CTRL:   rd_mux = {30'h00000000, ctrl_q};
      `CIC_OFF_STATUS: rd_mux = status_word;
      `CIC_OFF_ICTYPE: rd_mux = {27'h0000000, interrupt_line_count_field};
      `CIC_OFF_CALIB:  rd_mux = calib_word;
      `CIC_OFF_AFSR:   rd_mux = `CIC_AFSR_VALUE;
      `CIC_OFF_CONFIG: rd_mux = config_word;
      `CIC_OFF_IRQ_LO: rd_mux = irq_wide[31:0];
      `CIC_OFF_IRQ_HI: rd_mux = irq_wide[63:32];
      default: begin
        rd_mux = 32'h00000000;
        hit    = 1'b0;
      end
    endcase
  end

  // no wait states: data and ready are registered in the setup cycle,
  // so the read mux never sits on a combinational path to prdata
  reg  [31:0] prdata_d;
  reg         pslverr_d;

  always @* begin
    prdata_d  = 32'h00000000;
    pslverr_d = 1'b0;
    if (setup) begin
      prdata_d  = pwrite ? 32'h00000000 : rd_mux;
      pslverr_d = ~hit;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      prdata  <= prdata_d;
      pslverr <= pslverr_d;
    end
  end

  // ---------------------------------------------------------------
  // register writes
  wire wr_ctrl   = wr_acc & (paddr == `CIC_OFF_CTRL);
  wire wr_status = wr_acc & (paddr == `CIC_OFF_STATUS);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `CIC_CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= pwdata[1:0];
    end
  end

  // sticky flags, write one to clear; a new request wins over the clear
  reg st_rst_seen_d;
  reg st_rst_slow_d;

  always @* begin
    st_rst_seen_d = st_rst_seen_q;
    st_rst_slow_d = st_rst_slow_q;
    if (wr_status & pwdata[`CIC_ST_RST_SEEN]) begin
      st_rst_seen_d = 1'b0;
    end
    if (wr_status & pwdata[`CIC_ST_RST_IN_SLOW]) begin
      st_rst_slow_d = 1'b0;
    end
    if (req_rise) begin
      st_rst_seen_d = 1'b1;
    end
    // flags misuse seen from software in low speed mode
    if (req_rise & slow_sync) begin
      st_rst_slow_d = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_rst_seen_q <= 1'b0;
      st_rst_slow_q <= 1'b0;
    end else begin
      st_rst_seen_q <= st_rst_seen_d;
      st_rst_slow_q <= st_rst_slow_d;
    end
  end

endmodule // cic_core_integration

/* verification/cic_core_model.sv */
`timescale 1ns/1ps

module cic_core_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic go,
  input  wire logic slow,
  output logic      system_reset_request,
  output logic      core_output_a,
  output logic      deep_sleep_output,
  output logic      core_event_out,
  output logic      core_excl_req
);
  logic [1:0] hold_q;
  // unused outputs churn every cycle; nothing may follow them
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {core_output_a, deep_sleep_output, core_event_out, core_excl_req} <= 4'h0;
    end else begin
      {core_output_a, deep_sleep_output, core_event_out, core_excl_req} <=
        ~{core_output_a, deep_sleep_output, core_event_out, core_excl_req};
    end
  end
  // request held three cycles; never raised in low speed mode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_q <= 2'h0;
      system_reset_request <= 1'b0;
    end else begin
      if (go && !slow) begin
        hold_q <= 2'h3;
      end else if (hold_q != 2'h0) begin
        hold_q <= hold_q - 2'h1;
      end
      system_reset_request <= (go && !slow) || (hold_q > 2'h1);
    end
  end
endmodule // cic_core_model

/* verification/cic_core_integration_chk.sv */
`timescale 1ns/1ps

module cic_core_integration_chk #(
  parameter IRQ_N = 37
) (
  input wire              pclk,
  input wire              presetn,
  input wire              psel,
  input wire              penable,
  input wire              pready,
  input wire [31:0]       prdata,
  input wire              pslverr,
  input wire [IRQ_N-1:0]  irq_src,
  input wire              system_reset_request,
  input wire [IRQ_N-1:0]  core_irq,
  input wire [23:0]       calib_value,
  input wire              no_reference_flag,
  input wire              calibration_inexact_flag,
  input wire [4:0]        interrupt_line_count_field,
  input wire [3:0]        cfg_priority_bits,
  input wire              cfg_mpu_present,
  input wire              cfg_trace_present,
  input wire              core_event_in,
  input wire [31:0]       core_aux_fault,
  input wire              core_excl_okay,
  input wire              sys_reset_n
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  irq_pass_a: assert property (core_irq == $past(irq_src, 3))
    else $error("interrupt lines not passed after three cycles");
  calib_fixed_a: assert property (calib_value == 24'h0009C4 && !no_reference_flag
    && !calibration_inexact_flag) else $error("calibration outputs wrong");
  line_prio_a: assert property (interrupt_line_count_field == 5'h01
    && cfg_priority_bits == 4'h3) else $error("line count or priority bits wrong");
  build_opt_a: assert property (!cfg_mpu_present && cfg_trace_present)
    else $error("build options wrong");
  ties_zero_a: assert property (!core_event_in && core_aux_fault == 32'h00000000
    && !core_excl_okay) else $error("sideband tie not zero");
  rst_cause_a: assert property ($fell(sys_reset_n) |-> $past(system_reset_request)
    && !$past(system_reset_request, 2)) else $error("reset pulse without request edge");
  rst_len_a: assert property ($fell(sys_reset_n) |-> (!sys_reset_n)[*8] ##1 !sys_reset_n
    ##1 !sys_reset_n ##1 sys_reset_n) else $error("reset pulse length wrong");
  apb_ready_a: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("ready not one cycle after setup");
  apb_idle_a: assert property (!pready |-> prdata == 32'h00000000 && !pslverr)
    else $error("read data outside access");
endmodule // cic_core_integration_chk

bind cic_core_integration cic_core_integration_chk #(.IRQ_N(IRQ_N)) u_chk (.*);

/* verification/cic_core_integration_test.sv */
`timescale 1ns/1ps

module cic_core_integration_test;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, osc = 0, slow = 0, go = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, rd;
  logic [36:0] irq_src = 37'h0000000000;
  logic err;
  wire pready, pslverr, sreq, lk, ds, ev, ex, tick, sys_n;
  wire [31:0] prdata;
  wire [36:0] core_irq;
  int fail_count = 0, total_checks = 0, cyc = 0, n, i;
  // address, expected data, expected error
  logic [40:0] rows [0:7] = '{{8'h00, 32'h00000003, 1'b0}, {8'h08, 32'h00000001, 1'b0},
    {8'h0C, 32'h000009C4, 1'b0}, {8'h10, 32'h00000000, 1'b0}, {8'h14, 32'h00250203, 1'b0},
    {8'h18, 32'hA5A5F00F, 1'b0}, {8'h1C, 32'h00000015, 1'b0}, {8'h20, 32'h00000000, 1'b1}};

  always #50 pclk = ~pclk;
  // oscillator at eight pclk periods so every rise is counted
  initial #30 forever #400 osc = ~osc;

  cic_core_model u_core (.pclk(pclk), .presetn(presetn), .go(go), .slow(slow),
    .system_reset_request(sreq), .core_output_a(lk), .deep_sleep_output(ds),
    .core_event_out(ev), .core_excl_req(ex));
  cic_core_integration dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .high_speed_osc_input(osc), .slow_clock_mode(slow), .irq_src(irq_src),
    .system_reset_request(sreq), .core_output_a(lk), .deep_sleep_output(ds),
    .core_event_out(ev), .core_excl_req(ex), .core_irq(core_irq), .tick_ref_clk(tick),
    .calib_value(), .no_reference_flag(), .calibration_inexact_flag(),
    .interrupt_line_count_field(), .cfg_priority_bits(), .cfg_mpu_present(),
    .cfg_trace_present(), .core_event_in(), .core_aux_fault(), .core_excl_okay(),
    .sys_reset_n(sys_n));

  task check(input logic [36:0] seen, input logic [36:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata; err = pslverr;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask

  task stop_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin fail_count++; stop_test; end
  end

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1; irq_src <= 37'h15A5A5F00F;
    @(posedge pclk);
    check(sys_n, 1);
    apb(1, 8'h0C, 32'hFFFFFFFF); // read-only write ignored
    apb(1, 8'h10, 32'hFFFFFFFF);
    for (i = 0; i < 8; i++) begin
      apb(0, rows[i][40:33], 32'h00000000);
      check(rd, rows[i][32:1]);
      check(err, rows[i][0]);
    end
    $display("register table done");
    // one half period of the tick reference is 16 oscillator rises
    @(posedge pclk); #1 n = tick;
    while (tick === n[0] && cyc < 2000) begin @(posedge pclk); #1; end
    n = 0; i = tick;
    while (tick === i[0] && n < 1000) begin @(posedge pclk); #1 n++; end
    check(n, 128);
    apb(1, 8'h00, 32'h00000002);
    @(posedge pclk); #1 i = tick;
    repeat (300) @(posedge pclk);
    check(tick, i[0]);
    $display("tick reference done");
    @(posedge pclk) go <= 1;
    @(posedge pclk) go <= 0;
    @(posedge pclk); #1 check(sys_n, 0);
    n = 0;
    while (sys_n === 1'b0 && n < 100) begin @(posedge pclk); #1 n++; end
    check(n, 10);
    apb(1, 8'h00, 32'h00000001);
    @(posedge pclk) go <= 1;
    @(posedge pclk) go <= 0;
    repeat (4) @(posedge pclk);
    check(sys_n, 1);
    apb(0, 8'h04, 32'h00000000);
    check(rd[0], 1);
    apb(1, 8'h04, 32'h00000001);
    apb(0, 8'h04, 32'h00000000);
    check(rd[0], 0);
    slow <= 1;
    @(posedge pclk) go <= 1;
    @(posedge pclk) go <= 0;
    repeat (12) @(posedge pclk);
    apb(0, 8'h04, 32'h00000000);
    check(rd[2:0], 3'h2);
    $display("reset request done");
    stop_test;
  end
endmodule // cic_core_integration_test
